//--- rtl/fbe_sequencer.sv
// block erase sequencer with its Wishbone register slave
`timescale 1ns/1ns
module fbe_sequencer #(
  parameter int unsigned ERASE_CYCLES = fbe_pkg::ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fbe_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic programmerBulkReq,
  output logic cpuStall,
  output logic flashEraseActive,
  output logic [fbe_pkg::BLOCK_W-1:0] flashEraseBlock,
  output logic flashBulkErase
);
  import fbe_pkg::*;

  // bus decode
  logic ack_q;
  logic [31:0] rdata_q;
  wire logic [13:0] regIdx = wb_adr_i[ADDR_W-1:2];
  wire logic access = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wrLow = access && wb_we_i && wb_sel_i[0];
  wire logic wrAny = access && wb_we_i;
  wire logic hitControl = (regIdx == IDX_CONTROL);
  wire logic hitUnlock = (regIdx == IDX_UNLOCK);
  wire logic hitTblptr = (regIdx == IDX_TABLE_POINTER);
  wire logic hitStatus = (regIdx == IDX_STATUS);
  wire logic wrControl = wrLow && hitControl;
  wire logic wrUnlock = wrLow && hitUnlock;
  wire logic [7:0] wByte = wb_dat_i[7:0];

  // control and pointer registers
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [TABLE_POINTER_W-1:0] tablePointer_q;
  logic [TABLE_POINTER_W-1:0] tablePointer_d;
  logic [7:0] eraseCount_q;
  logic [BLOCK_W-1:0] eraseBlock_q;

  fbe_unlock_e unlock_q;
  fbe_unlock_e unlock_d;
  fbe_erase_e erase_q;
  fbe_erase_e erase_d;

  fbe_timer_if tmrIf ();

  // programmer pin crosses in through two flops before anything looks at it
  logic bulkMeta_q;
  logic bulkSync_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      bulkMeta_q <= 1'b0;
      bulkSync_q <= 1'b0;
    end
    else
    begin
      bulkMeta_q <= programmerBulkReq;
      bulkSync_q <= bulkMeta_q;
    end
  end

  // bulk erase is reachable only from the programmer pin, never from a register
  assign flashBulkErase = bulkSync_q && (erase_q == ERS_IDLE); // [R4]

  wire logic busy = (erase_q != ERS_IDLE);

  // the new control value as software would leave it, used to judge a start
  wire logic [7:0] ctlWritten = (control_q & ~CTL_WMASK) | (wByte & CTL_WMASK);
  wire logic startReq = wrControl && wByte[CTL_START] && !busy;
  wire logic targetOk = ctlWritten[CTL_PGM_SEL] && !ctlWritten[CTL_CFG_SEL]; // [R5]
  wire logic enableOk = ctlWritten[CTL_MOD_EN]; // [R6]
  wire logic eraseOk = ctlWritten[CTL_ERASE_SEL]; // [R7]
  wire logic armedOk = (unlock_q == UNL_ARMED); // [R8]
  wire logic startErase = startReq && armedOk && targetOk && enableOk && eraseOk && !bulkSync_q; // [R10]
  // a refused start after a complete unlock is flagged; without the unlock it is silent
  wire logic startRefused = startReq && armedOk && !startErase; // [R9]
  wire logic timerDone = tmrIf.done;

  // unlock detector: the key register has no storage, it only steers this machine
  always_comb
  begin
    unlock_d = unlock_q;
    unique case (unlock_q)
      UNL_LOCKED:
      begin
        if (wrUnlock && wByte == KEY_FIRST) // [R14]
          unlock_d = UNL_HALF;
      end
      UNL_HALF:
      begin
        if (wrUnlock && wByte == KEY_SECOND) // [R8]
          unlock_d = UNL_ARMED;
        else if (wrUnlock && wByte == KEY_FIRST)
          unlock_d = UNL_HALF;
        else if (wrAny)
          unlock_d = UNL_LOCKED; // [R9]
      end
      UNL_ARMED:
      begin
        // only the very next write may use the unlock, whatever it is
        if (wrAny)
          unlock_d = UNL_LOCKED; // [R8]
      end
      default:
        unlock_d = UNL_LOCKED;
    endcase
  end

  // erase sequencing
  always_comb
  begin
    erase_d = erase_q;
    unique case (erase_q)
      ERS_IDLE:
      begin
        if (startErase)
          erase_d = ERS_RUN; // [R10]
      end
      ERS_RUN:
      begin
        if (timerDone)
          erase_d = ERS_DONE; // [R12]
      end
      ERS_DONE:
        erase_d = ERS_IDLE;
      default:
        erase_d = ERS_IDLE;
    endcase
  end

  assign tmrIf.start = startErase;

  // control register: the start bit reads back as set while the erase runs
  always_comb
  begin
    control_d = control_q;
    if (wrControl && !busy)
      control_d = ctlWritten;
    control_d[CTL_START] = startErase || (erase_q == ERS_RUN && !timerDone); // [R12]
    if (wrControl && !busy && !wByte[CTL_ERR])
      control_d[CTL_ERR] = 1'b0;
    // set wins over a clear in the same cycle
    if (startRefused)
      control_d[CTL_ERR] = 1'b1;
  end

  // pointer may not move under a running erase
  always_comb
  begin
    tablePointer_d = tablePointer_q;
    if (access && wb_we_i && hitTblptr && !busy) // [R13]
    begin
      if (wb_sel_i[0])
        tablePointer_d[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        tablePointer_d[15:8] = wb_dat_i[15:8];
      if (wb_sel_i[2])
        tablePointer_d[TABLE_POINTER_W-1:16] = wb_dat_i[TABLE_POINTER_W-1:16];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      control_q <= CTL_RESET;
      tablePointer_q <= TABLE_POINTER_RESET;
      unlock_q <= UNL_LOCKED;
      erase_q <= ERS_IDLE;
    end
    else
    begin
      control_q <= control_d;
      tablePointer_q <= tablePointer_d;
      unlock_q <= unlock_d;
      erase_q <= erase_d;
    end
  end

  // the block number is latched at start; the low six pointer bits never reach the array
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      eraseBlock_q <= '0;
      eraseCount_q <= 8'h00;
    end
    else
    begin
      if (startErase)
        eraseBlock_q <= tablePointer_q[TABLE_POINTER_W-1:BLOCK_LSB]; // [R2]
      if (timerDone && erase_q == ERS_RUN)
        eraseCount_q <= eraseCount_q + 8'h01;
    end
  end

  // the array only ever sees a block number, so no word or part block can be erased
  assign flashEraseBlock = eraseBlock_q; // [R1] [R3]
  assign flashEraseActive = (erase_q == ERS_RUN); // [R1]
  // the stall covers the whole timed cycle and drops as the timer finishes
  assign cpuStall = (erase_q == ERS_RUN); // [R11]

  fbe_erase_timer #(
    .CYCLES(ERASE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .tmr(tmrIf.timer)
  );

  // read mux; the key register and unmapped words read as zero
  wire logic [31:0] statusWord = {16'h0000, eraseCount_q, 5'h00, bulkSync_q, armedOk, busy};
  wire logic [31:0] readMux =
    hitControl ? {24'h000000, control_q} :
    hitTblptr ? {10'h000, tablePointer_q} :
    hitStatus ? statusWord :
    32'h00000000; // [R14]

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= access;
      if (access && !wb_we_i)
        rdata_q <= readMux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule

//--- rtl/fbe_pkg.sv
// constants and types shared by the flash block erase sequencer
// Function
// [R1] Program flash is erased only in whole blocks of 32 words, that is 64 bytes.
// [R2] A software erase takes its block from table pointer bits 21:6 and ignores bits 5:0.
// [R3] No single word is ever erased; every erase covers at least a whole block.
// [R4] Bulk erase of more than one block comes only from the external programmer, never from software.
// [R5] Software selects program memory and deselects configuration space before an erase.
// [R6] Software sets the modify enable bit first, and without it no erase is performed.
// [R7] With erase select set, the next started cycle is a block erase and not a write.
// [R8] The erase starts only after 55h then 0AAh to the unlock key, directly followed by the start bit.
// [R9] Any attempt that breaks the unlock sequence leaves the flash untouched.
// [R10] Setting start after a valid unlock with erase selected begins erasing the addressed block.
// [R11] The CPU is stalled for the whole erase, about 2 ms by the internal timer.
// [R12] The internal timer ends the erase on its own and then releases the CPU.
// [R13] Software first loads the table pointer with an address inside the block to erase.
// [R14] The unlock key register stores nothing; writes only feed the sequence detector.
// [R15] Software disables interrupts around the unlock sequence and the erase.
package fbe_pkg;

  localparam int ADDR_W = 16;
  localparam int TABLE_POINTER_W = 22;
  localparam int BLOCK_LSB = 6;
  localparam int BLOCK_W = TABLE_POINTER_W - BLOCK_LSB;
  localparam int WORDS_PER_BLOCK = 32;
  localparam int BYTES_PER_BLOCK = 64;

  // register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_CONTROL = 14'hfa6;
  localparam logic [13:0] IDX_UNLOCK = 14'hfa7;
  localparam logic [13:0] IDX_TABLE_POINTER = 14'hf80;
  localparam logic [13:0] IDX_STATUS = 14'hf81;

  // control register fields
  localparam int CTL_PGM_SEL = 7;
  localparam int CTL_CFG_SEL = 6;
  localparam int CTL_ERASE_SEL = 4;
  localparam int CTL_ERR = 3;
  localparam int CTL_MOD_EN = 2;
  localparam int CTL_START = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'hd4;

  // status register fields
  localparam int STS_BUSY = 0;
  localparam int STS_ARMED = 1;
  localparam int STS_BULK = 2;
  localparam int STS_COUNT_LSB = 8;
  localparam logic [TABLE_POINTER_W-1:0] TABLE_POINTER_RESET = 22'h000000;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_US = 2000;
  localparam int unsigned ERASE_CYCLES = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    UNL_LOCKED = 3'b001,
    UNL_HALF = 3'b010,
    UNL_ARMED = 3'b100
  } fbe_unlock_e;

  typedef enum logic [2:0] {
    ERS_IDLE = 3'b001,
    ERS_RUN = 3'b010,
    ERS_DONE = 3'b100
  } fbe_erase_e;

endpackage

//--- rtl/fbe_timer_if.sv
// handshake between the erase sequencer and its programming timer
`timescale 1ns/1ns
interface fbe_timer_if;
  logic start;
  logic busy;
  logic done;

  modport ctrl (
    output start,
    input busy,
    input done
  );

  modport timer (
    input start,
    output busy,
    output done
  );
endinterface

//--- rtl/fbe_erase_timer.sv
// self-timed programming timer for one block erase
`timescale 1ns/1ns
module fbe_erase_timer #(
  parameter int unsigned CYCLES = fbe_pkg::ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  fbe_timer_if.timer tmr
);
  import fbe_pkg::*;

  logic [31:0] count_q;
  logic busy_q;
  wire logic expire = busy_q && (count_q == 32'h00000000);

  assign tmr.busy = busy_q;
  // done is taken straight from the last count so the stall spans exactly CYCLES clocks
  assign tmr.done = expire; // [R12]

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      count_q <= 32'h00000000;
      busy_q <= 1'b0;
    end
    else
    begin
      if (tmr.start && !busy_q)
      begin
        busy_q <= 1'b1;
        count_q <= 32'(CYCLES - 1);
      end
      else if (expire)
        busy_q <= 1'b0; // [R12]
      else if (busy_q)
        count_q <= count_q - 32'h00000001;
    end
  end
endmodule

//--- test/fbe_sequencer_monitor.sv
// port assertions for the flash block erase sequencer
`timescale 1ns/1ns
module fbe_sequencer_monitor #(
  parameter int unsigned ERASE_CYCLES = 20
) (
  input logic core_clk,
  input logic reset,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [fbe_pkg::ADDR_W-1:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic cpuStall,
  input logic flashEraseActive,
  input logic [fbe_pkg::BLOCK_W-1:0] flashEraseBlock,
  input logic flashBulkErase
);
  import fbe_pkg::*;
  int unsigned stallCnt_q;
  logic req;
  logic startReq;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign startReq = req && wb_we_i && wb_adr_i[15:2] == IDX_CONTROL && wb_dat_i[CTL_START];
  // counts high cycles so long stalls need no huge repetition
  always_ff @(posedge core_clk)
    stallCnt_q <= (reset || !cpuStall) ? 0 : stallCnt_q + 1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence sBegin;
    startReq ##1 $rose(cpuStall);
  endsequence
  sequence sRun;
    cpuStall [*8];
  endsequence
  a_ack_follows: assert property (req |=> wb_ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_start_cause: assert property ($rose(cpuStall) |-> $past(startReq) && wb_ack_o)
    else $error("stall without start write");
  a_stall_hold: assert property (sBegin |-> sRun) else $error("stall dropped early");
  a_stall_len: assert property ($fell(cpuStall) |-> stallCnt_q == ERASE_CYCLES)
    else $error("stall length wrong");
  a_stall_max: assert property (cpuStall |-> stallCnt_q < ERASE_CYCLES) else $error("stall too long");
  a_active_same: assert property (cpuStall == flashEraseActive) else $error("active differs from stall");
  a_block_held: assert property (cpuStall && $past(cpuStall) |-> $stable(flashEraseBlock))
    else $error("block moved mid erase");
  a_bulk_apart: assert property (flashBulkErase |-> !flashEraseActive) else $error("bulk with block erase");
endmodule

//--- test/test_flash_block_erase_sequencer.sv
// self-checking bench for the flash block erase sequencer
`timescale 1ns/1ns
module test_flash_block_erase_sequencer;
  import fbe_pkg::*;
  localparam int unsigned ERASE_N = 20;
  localparam logic [15:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [15:0] A_KEY = {IDX_UNLOCK, 2'b00};
  localparam logic [15:0] A_TBL = {IDX_TABLE_POINTER, 2'b00};
  localparam logic [15:0] A_STS = {IDX_STATUS, 2'b00};
  logic core_clk = 0;
  logic reset = 1;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [15:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0;
  logic programmerBulkReq = 0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cpuStall, flashEraseActive, flashBulkErase;
  logic [BLOCK_W-1:0] flashEraseBlock;
  logic [31:0] expQ[$];
  int n_errors = 0;
  int checked = 0;
  int runLen = 0;
  int nRuns = 0;
  int cnt = 0;
  int seed;
  logic [21:0] ptr;
  logic [7:0] bad[3] = '{8'h86, 8'hd6, 8'h92};
  always #5 core_clk = ~core_clk;
  fbe_sequencer #(.ERASE_CYCLES(ERASE_N)) dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .programmerBulkReq(programmerBulkReq), .cpuStall(cpuStall),
    .flashEraseActive(flashEraseActive), .flashEraseBlock(flashEraseBlock), .flashBulkErase(flashBulkErase));
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      n_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!w)
      expQ.push_back(d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= w ? d : 32'h0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (n >= 50)
    begin
      n_errors++;
      conclude();
    end
    @(posedge core_clk);
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    while (cpuStall !== 1'b0 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100)
    begin
      n_errors++;
      conclude();
    end
  endtask
  // read results are paired with the oldest noted expectation
  always @(posedge core_clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0)
      check(wb_dat_o, expQ.pop_front(), "read data");
  always @(posedge core_clk)
    if (cpuStall === 1'b1)
      runLen++;
    else if (runLen != 0)
    begin
      check(runLen, ERASE_N, "stall length");
      nRuns++;
      runLen = 0;
    end
  initial
  begin
    seed = 32'hc29628eb;
    repeat (8) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    bus(0, A_CTL, 0);
    bus(0, A_STS, 0);
    bus(0, A_KEY, 0);
    bus(0, 16'h0100, 0);
    for (int i = 0; i < 3; i++)
    begin
      ptr = 22'($random(seed));
      bus(1, A_TBL, {10'h0, ptr});
      bus(1, A_CTL, 32'h94);
      bus(1, A_KEY, 32'h55);
      if (i == 1)
        bus(1, A_KEY, 32'h55);
      bus(1, A_KEY, 32'haa);
      bus(0, A_STS, cnt << 8 | 2);
      bus(1, A_CTL, 32'h96);
      check(flashEraseBlock, ptr[21:6], "erase block");
      bus(1, A_TBL, {10'h0, ~ptr});
      bus(0, A_CTL, 32'h96);
      waitIdle();
      cnt++;
      bus(0, A_TBL, {10'h0, ptr});
      bus(0, A_STS, cnt << 8);
      bus(0, A_CTL, 32'h94);
    end
    bus(1, A_KEY, 32'h55);
    bus(1, A_TBL, 0);
    bus(1, A_KEY, 32'haa);
    bus(1, A_CTL, 32'h96);
    bus(1, A_KEY, 32'haa);
    bus(1, A_KEY, 32'h55);
    bus(1, A_CTL, 32'h96);
    bus(0, A_CTL, 32'h94);
    foreach (bad[k])
    begin
      bus(1, A_KEY, 32'h55);
      bus(1, A_KEY, 32'haa);
      bus(1, A_CTL, bad[k]);
      bus(0, A_CTL, bad[k] & 8'hd4 | 8'h08);
      bus(1, A_CTL, 32'h94);
    end
    programmerBulkReq <= 1;
    repeat (4) @(posedge core_clk);
    check(flashBulkErase, 1, "bulk on");
    bus(0, A_STS, cnt << 8 | 4);
    bus(1, A_KEY, 32'h55);
    bus(1, A_KEY, 32'haa);
    bus(1, A_CTL, 32'h96);
    programmerBulkReq <= 0;
    repeat (4) @(posedge core_clk);
    check(flashBulkErase, 0, "bulk off");
    check(nRuns, cnt, "erase count");
    conclude();
  end
endmodule
bind fbe_sequencer fbe_sequencer_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) mon (.core_clk(core_clk),
  .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .cpuStall(cpuStall), .flashEraseActive(flashEraseActive),
  .flashEraseBlock(flashEraseBlock), .flashBulkErase(flashBulkErase));
